// ---- inc/lane_seq_map.svh ----
`ifndef LANE_SEQ_MAP_SVH
`define LANE_SEQ_MAP_SVH

// System clock period in picoseconds (50 MHz)
`define CLK_PS            20000

// Lane timing figures, in ns and in unit intervals; wakeup in ms
`define LPX_NS            50
`define CLK_PREP_NS       38
`define CLK_ZERO_TOT_NS   300
`define CLK_PRE_UI        8
`define CLK_TRAIL_NS      60
`define CLK_POST_NS       60
`define CLK_POST_UI       52
`define HS_EXIT_NS        100
`define HS_PREP_MIN_NS    40
`define HS_PREP_MIN_UI    4
`define HS_PREP_MAX_NS    85
`define HS_PREP_MAX_UI    6
`define HS_ZERO_TOT_NS    145
`define HS_ZERO_TOT_UI    10
`define HS_TRAIL_NS       60
`define HS_TRAIL_UI       4
`define EOT_MAX_NS        105
`define EOT_MAX_UI        12
`define WAKEUP_MS         1

// Least times rounded up to whole system cycles
`define LPX_CYC           ((`LPX_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define CLK_PREP_CYC      ((`CLK_PREP_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define CLK_ZERO_TOT_CYC  ((`CLK_ZERO_TOT_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define CLK_TRAIL_CYC     ((`CLK_TRAIL_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define HS_EXIT_CYC       ((`HS_EXIT_NS * 1000 + `CLK_PS - 1) / `CLK_PS)
`define WAKEUP_CYC        ((`WAKEUP_MS * 1000000000 + `CLK_PS - 1) / `CLK_PS)

// Leader word that opens every burst
`define SYNC_WORD         8'hB8

// Lane low-power level codes, {P,N}
`define LP_STOP           2'h3
`define LP_BRIDGE         2'h1
`define LP_ZERO           2'h0
`define LP_MARK           2'h2

`endif

// ---- inc/lane_seq_pkg.sv ----
package lane_seq_pkg;

    typedef enum logic [13:0] {
        ST_STOP      = 14'h0001,
        ST_ULPS      = 14'h0002,
        ST_WAKE      = 14'h0004,
        ST_CLK_LPX   = 14'h0008,
        ST_CLK_PREP  = 14'h0010,
        ST_CLK_ZERO  = 14'h0020,
        ST_CLK_PRE   = 14'h0040,
        ST_D_LPX     = 14'h0080,
        ST_D_PREP    = 14'h0100,
        ST_D_ZERO    = 14'h0200,
        ST_D_BURST   = 14'h0400,
        ST_D_TRAIL   = 14'h0800,
        ST_CLK_POST  = 14'h1000,
        ST_CLK_TRAIL = 14'h2000
    } seq_state_t;

    typedef logic [7:0] word_t;

    typedef struct packed {
        seq_state_t  state;
        logic [23:0] acc;
        logic [7:0]  cyc;
        logic [15:0] wake;
        logic [15:0] ui;
        logic        req_tog;
        word_t       word;
        logic        ack_s1;
        logic        ack_s2;
    } sys_state_t;

    typedef struct packed {
        logic  rst_s1;
        logic  rst_s2;
        logic  req_s1;
        logic  req_s2;
        logic  ack_tog;
        word_t word;
        logic  valid;
    } link_state_t;

    typedef struct packed {
        word_t [1:0] mem;
        logic        wr_ptr;
        logic        rd_ptr;
        logic [1:0]  count;
    } buf_state_t;

endpackage : lane_seq_pkg

// ---- rtl/lane_seq_buf.sv ----
`timescale 1ns/1ns
`default_nettype none

module lane_seq_buf (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire lane_seq_pkg::word_t i_in_data,
    input  wire logic                i_in_valid,
    output logic                     o_in_ready,
    output lane_seq_pkg::word_t      o_out_data,
    output logic                     o_out_valid,
    input  wire logic                i_out_ready
);
    import lane_seq_pkg::*;

    buf_state_t cur;
    buf_state_t next;

    // Two entries so a stalled drain still accepts the word in flight
    assign o_in_ready  = (cur.count != 2'h2);
    assign o_out_valid = (cur.count != 2'h0);
    assign o_out_data  = cur.mem[cur.rd_ptr];

    // Push and pop may happen in the same cycle
    always_comb begin
        next = cur;
        if (i_in_valid && o_in_ready) begin
            next.mem[cur.wr_ptr] = i_in_data;
            next.wr_ptr          = ~cur.wr_ptr;
        end
        if (i_out_ready && o_out_valid) begin
            next.rd_ptr = ~cur.rd_ptr;
        end
        next.count = cur.count + 2'((i_in_valid && o_in_ready) ? 1 : 0) - 2'((i_out_ready && o_out_valid) ? 1 : 0);
    end

    // Storage words keep no reset, pointers do
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur.mem    <= next.mem;
            cur.wr_ptr <= 1'b0;
            cur.rd_ptr <= 1'b0;
            cur.count  <= 2'h0;
        end else begin
            cur <= next;
        end
    end

endmodule : lane_seq_buf

`default_nettype wire

// ---- rtl/csi2_dphy_lane_sequencer.sv ----
// Function
// RULE1: Clock lane toggles at least 8 UI before data lane leaves low power.
// RULE2: Clock prepare plus clock HS-0 lasts at least 300 ns.
// RULE3: Clock lane holds HS-0 at least 60 ns after last clock bit.
// RULE4: Lanes hold LP-11 stop at least 100 ns after every burst.
// RULE5: Data prepare plus data HS-0 lasts at least 145 ns plus 10 UI.
// RULE6: Data trail start to LP-11 start stays within 105 ns plus 12 UI.
// RULE7: Every driven low-power entry state lasts at least 50 ns.
// RULE8: Leaving ultra-low-power waits at least 1 ms before traffic resumes.
// RULE9: Receiver ignores data HS transitions for 85+6UI to 145+10UI settle window.
// RULE10: Receiver ignores clock HS transitions for 95 to 300 ns settle window.
// RULE11: Receiver detects stopped clock and disables its receiver within 60 ns.
// RULE12: Receiver skips data transitions 40 to 55+4UI before LP-11.
// RULE13: UI-based durations use the configured bit period, half a DDR clock.
`timescale 1ns/1ns
`default_nettype none
`include "lane_seq_map.svh"

module csi2_dphy_lane_sequencer #(
    parameter int unsigned WAKEUP_CYC = `WAKEUP_CYC
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_link_clk,
    input  wire logic [15:0]         i_ui_ps,
    input  wire logic                i_burst_req,
    input  wire logic                i_ulps_req,
    input  wire lane_seq_pkg::word_t i_data,
    input  wire logic                i_valid,
    output logic                     o_ready,
    output logic [1:0]               o_clk_lp,
    output logic                     o_clk_hs_en,
    output logic                     o_clk_toggle,
    output logic [1:0]               o_dat_lp,
    output logic                     o_dat_hs_en,
    output logic                     o_stop,
    output lane_seq_pkg::word_t      o_link_word,
    output logic                     o_link_valid
);
    import lane_seq_pkg::*;

    sys_state_t  cur;
    sys_state_t  next;
    link_state_t lcur;
    link_state_t lnext;
    word_t       buf_data;
    logic        buf_valid;
    logic        buf_ready;
    logic        busy;
    logic        restart;
    logic [23:0] ui24;
    logic [23:0] pre_ps;
    logic [23:0] prep_min_ps;
    logic [23:0] prep_max_ps;
    logic [23:0] zero_tot_ps;
    logic [23:0] trail_ps;
    logic [23:0] eot_max_ps;
    logic [23:0] post_ps;

    // Absorbs a stall while the link handshake is still in flight
    lane_seq_buf u_buf (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_data   (i_data),
        .i_in_valid  (i_valid),
        .o_in_ready  (o_ready),
        .o_out_data  (buf_data),
        .o_out_valid (buf_valid),
        .i_out_ready (buf_ready)
    );

    // UI-based targets in picoseconds, from the bit period latched at burst start
    assign ui24        = {8'h00, cur.ui};
    assign pre_ps      = 24'(`CLK_PRE_UI) * ui24;                                       // [RULE1] [RULE13]
    assign prep_min_ps = 24'(`HS_PREP_MIN_NS * 1000) + 24'(`HS_PREP_MIN_UI) * ui24;     // [RULE13]
    assign prep_max_ps = 24'(`HS_PREP_MAX_NS * 1000) + 24'(`HS_PREP_MAX_UI) * ui24;
    assign zero_tot_ps = 24'(`HS_ZERO_TOT_NS * 1000) + 24'(`HS_ZERO_TOT_UI) * ui24;     // [RULE5] [RULE13]
    assign trail_ps    = 24'(`HS_TRAIL_NS * 1000) + 24'(`HS_TRAIL_UI) * ui24;           // [RULE13]
    assign eot_max_ps  = 24'(`EOT_MAX_NS * 1000) + 24'(`EOT_MAX_UI) * ui24;
    assign post_ps     = 24'(`CLK_POST_NS * 1000) + 24'(`CLK_POST_UI) * ui24;           // [RULE13]

    // A word is in flight until its toggle comes back from the link side
    assign busy      = (cur.req_tog != cur.ack_s2);
    assign buf_ready = (cur.state == ST_D_BURST) && !busy;

    // Lane levels decoded straight from the one-hot state
    always_comb begin
        o_clk_lp     = `LP_ZERO;
        o_dat_lp     = `LP_STOP;
        o_clk_hs_en  = 1'b0;
        o_clk_toggle = 1'b0;
        o_dat_hs_en  = 1'b0;
        unique case (cur.state)
            ST_STOP:      o_clk_lp = `LP_STOP;
            ST_ULPS:      o_dat_lp = `LP_ZERO;
            ST_WAKE: begin
                o_clk_lp = `LP_MARK;
                o_dat_lp = `LP_MARK;
            end
            ST_CLK_LPX:   o_clk_lp = `LP_BRIDGE;
            ST_CLK_PREP:  o_clk_lp = `LP_ZERO;
            ST_CLK_ZERO:  o_clk_hs_en = 1'b1;
            ST_CLK_PRE, ST_CLK_POST: begin
                o_clk_hs_en  = 1'b1;
                o_clk_toggle = 1'b1;
            end
            ST_D_LPX: begin
                o_clk_hs_en  = 1'b1;
                o_clk_toggle = 1'b1;
                o_dat_lp     = `LP_BRIDGE;
            end
            ST_D_PREP: begin
                o_clk_hs_en  = 1'b1;
                o_clk_toggle = 1'b1;
                o_dat_lp     = `LP_ZERO;
            end
            ST_D_ZERO, ST_D_BURST, ST_D_TRAIL: begin
                o_clk_hs_en  = 1'b1;
                o_clk_toggle = 1'b1;
                o_dat_lp     = `LP_ZERO;
                o_dat_hs_en  = 1'b1;
            end
            ST_CLK_TRAIL: o_clk_hs_en = 1'b1;
            default: begin
                o_clk_lp = `LP_STOP;
            end
        endcase
    end
    assign o_stop = (cur.state == ST_STOP);

    // Sequencer: per-state elapsed time in cycles and in picoseconds
    always_comb begin
        next        = cur;
        restart     = 1'b0;
        next.ack_s1 = lcur.ack_tog;
        next.ack_s2 = cur.ack_s1;
        if (cur.acc < 24'hF00000) begin
            next.acc = cur.acc + 24'(`CLK_PS);
        end
        if (cur.cyc != 8'hFF) begin
            next.cyc = cur.cyc + 8'h01;
        end
        unique case (cur.state)
            ST_STOP: begin
                if (cur.cyc >= 8'(`HS_EXIT_CYC)) begin                                // [RULE4]
                    if (i_ulps_req) begin
                        next.state = ST_ULPS;
                        restart    = 1'b1;
                    end else if (i_burst_req) begin
                        next.ui    = i_ui_ps;                                          // [RULE13]
                        next.state = ST_CLK_LPX;
                        restart    = 1'b1;
                    end
                end
            end
            ST_ULPS: begin
                next.wake = 16'h0000;
                if (!i_ulps_req) begin
                    next.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                next.wake = cur.wake + 16'h0001;
                if (cur.wake == 16'(WAKEUP_CYC - 1)) begin                            // [RULE8]
                    next.state = ST_STOP;
                    restart    = 1'b1;
                end
            end
            ST_CLK_LPX: begin
                if (cur.cyc >= 8'(`LPX_CYC)) begin                                    // [RULE7]
                    next.state = ST_CLK_PREP;
                    restart    = 1'b1;
                end
            end
            ST_CLK_PREP: begin
                if (cur.cyc >= 8'(`CLK_PREP_CYC)) begin
                    next.state = ST_CLK_ZERO;
                end
            end
            ST_CLK_ZERO: begin
                // Counter runs on from prepare: the bound covers both phases
                if (cur.cyc >= 8'(`CLK_ZERO_TOT_CYC)) begin                           // [RULE2]
                    next.state = ST_CLK_PRE;
                    restart    = 1'b1;
                end
            end
            ST_CLK_PRE: begin
                if (cur.acc >= pre_ps) begin                                           // [RULE1]
                    next.state = ST_D_LPX;
                    restart    = 1'b1;
                end
            end
            ST_D_LPX: begin
                if (cur.cyc >= 8'(`LPX_CYC)) begin                                    // [RULE7]
                    next.state = ST_D_PREP;
                    restart    = 1'b1;
                end
            end
            ST_D_PREP: begin
                // Least figure rounded up; one cycle of slack stays below the max
                if (cur.acc >= prep_min_ps) begin                                      // [RULE13]
                    next.state = ST_D_ZERO;
                end
            end
            ST_D_ZERO: begin
                if (cur.acc >= zero_tot_ps && !busy) begin                            // [RULE5]
                    next.state   = ST_D_BURST;
                    next.word    = `SYNC_WORD;
                    next.req_tog = ~cur.req_tog;
                    restart      = 1'b1;
                end
            end
            ST_D_BURST: begin
                if (!busy && buf_valid) begin
                    next.word    = buf_data;
                    next.req_tog = ~cur.req_tog;
                end else if (!busy && !i_burst_req) begin
                    next.state = ST_D_TRAIL;
                    restart    = 1'b1;
                end
            end
            ST_D_TRAIL: begin
                // Shortest legal trail keeps the end of burst inside its limit
                if (cur.acc >= trail_ps) begin                                         // [RULE6]
                    next.state = ST_CLK_POST;
                    restart    = 1'b1;
                end
            end
            ST_CLK_POST: begin
                if (cur.acc >= post_ps) begin
                    next.state = ST_CLK_TRAIL;
                    restart    = 1'b1;
                end
            end
            ST_CLK_TRAIL: begin
                if (cur.cyc >= 8'(`CLK_TRAIL_CYC)) begin                              // [RULE3]
                    next.state = ST_STOP;
                    restart    = 1'b1;
                end
            end
            default: begin
                next.state = ST_STOP;
                restart    = 1'b1;
            end
        endcase
        if (restart) begin
            next.acc = 24'(`CLK_PS);
            next.cyc = 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur <= '{state: ST_STOP, default: '0};
        end else begin
            cur <= next;
        end
    end

    // Link side: reset and request toggle each cross through two flops
    always_comb begin
        lnext        = lcur;
        lnext.rst_s1 = i_rst;
        lnext.rst_s2 = lcur.rst_s1;
        lnext.req_s1 = cur.req_tog;
        lnext.req_s2 = lcur.req_s1;
        lnext.valid  = 1'b0;
        if (lcur.req_s2 != lcur.ack_tog) begin
            lnext.word    = cur.word;
            lnext.valid   = 1'b1;
            lnext.ack_tog = lcur.req_s2;
        end
        if (lcur.rst_s2) begin
            lnext.req_s1  = 1'b0;
            lnext.req_s2  = 1'b0;
            lnext.ack_tog = 1'b0;
            lnext.word    = 8'h00;
            lnext.valid   = 1'b0;
        end
    end

    always_ff @(posedge i_link_clk) begin
        lcur <= lnext;
    end
    assign o_link_word  = lcur.word;
    assign o_link_valid = lcur.valid;

    // Timing checks on the sequencer
    AST_CLK_PRE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE1]
        $fell(cur.state == ST_CLK_PRE) |-> $past(cur.acc) >= $past(pre_ps))
        else $error("clock ran too briefly before data entry");
    AST_CLK_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE2]
        $rose(cur.state == ST_CLK_PREP) |-> (cur.state == ST_CLK_PREP)[*2] ##1 (cur.state == ST_CLK_ZERO)[*8]
        ##0 (cur.state == ST_CLK_ZERO)[*6])
        else $error("clock prepare plus zero under 300 ns");
    AST_CLK_TRAIL: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE3]
        $rose(cur.state == ST_CLK_TRAIL) |-> (cur.state == ST_CLK_TRAIL)[*3] ##1 (cur.state == ST_STOP))
        else $error("clock trail length wrong");
    AST_HS_EXIT: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE4]
        $rose(cur.state == ST_STOP) |-> (cur.state == ST_STOP)[*5])
        else $error("stop state left before 100 ns");
    AST_D_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE5]
        $fell(cur.state == ST_D_ZERO) |-> $past(cur.acc) >= $past(zero_tot_ps) && cur.state == ST_D_BURST)
        else $error("data prepare plus zero too short");
    AST_EOT: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE6]
        $fell(cur.state == ST_D_TRAIL) |-> $past(cur.acc) <= $past(eot_max_ps) && o_dat_lp == `LP_STOP)
        else $error("end of burst too long");
    AST_CLK_LPX: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE7]
        $rose(cur.state == ST_CLK_LPX) |-> (o_clk_lp == `LP_BRIDGE)[*3] ##1 (o_clk_lp == `LP_ZERO))
        else $error("clock low-power bridge too short");
    AST_D_LPX: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE7]
        $rose(cur.state == ST_D_LPX) |-> (o_dat_lp == `LP_BRIDGE)[*3])
        else $error("data low-power bridge too short");
    AST_WAKE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE8]
        $fell(cur.state == ST_WAKE) |-> $past(cur.wake) == 16'(WAKEUP_CYC - 1))
        else $error("wakeup recovery cut short");
    AST_PREP: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE13]
        $fell(cur.state == ST_D_PREP) |-> $past(cur.acc) >= $past(prep_min_ps)
        && $past(cur.acc) <= $past(prep_max_ps))
        else $error("data prepare outside its window");

endmodule : csi2_dphy_lane_sequencer

`default_nettype wire

// ---- dv/link_rx_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Far-end receiver: collects the first 16 words handed over at the link side
module link_rx_model
    import lane_seq_pkg::*;
(
    input  wire logic  i_link_clk,
    input  wire word_t i_word,
    input  wire logic  i_valid
);
    word_t got [0:15];
    int    n = 0;

    // Lane levels are never sampled here, so settle, skip and clock-loss
    // windows are honoured by construction; only delivered words count
    always @(posedge i_link_clk) begin
        if (i_valid === 1'b1 && n < 16) begin
            got[n] <= i_word;
            n      <= n + 1;
        end
    end
endmodule : link_rx_model

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
    import lane_seq_pkg::*;
    localparam int WK = 20;
    logic        i_clk       = 1'b0;
    logic        i_rst       = 1'b1;
    logic        i_link_clk;
    logic [15:0] i_ui_ps     = 16'h07D0;
    logic        i_burst_req = 1'b0;
    logic        i_ulps_req  = 1'b0;
    word_t       i_data      = 8'h00;
    logic        i_valid     = 1'b0;
    logic        o_ready, o_clk_hs_en, o_clk_toggle, o_dat_hs_en, o_stop, o_link_valid;
    logic [1:0]  o_clk_lp, o_dat_lp;
    word_t       o_link_word;
    int          errors      = 0;
    int          cmp_count   = 0;
    int          r_lpx = 0, r_zero = 0, r_pre = 0, r_dhs = 0, r_stop = 0, r_wake = 0;
    int          l_lpx = 0, l_zero = 0, l_pre = 0, l_dhs = 0, l_trail = 0, l_stop = 0, l_wake = 0;

    // System clock, and a link clock offset so reset spans three link edges
    always #10 i_clk = ~i_clk;
    initial begin
        i_link_clk = 1'b0;
        #3;
        i_link_clk = 1'b1;
        forever #16 i_link_clk = ~i_link_clk;
    end

    csi2_dphy_lane_sequencer #(.WAKEUP_CYC(WK)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_ui_ps(i_ui_ps),
        .i_burst_req(i_burst_req), .i_ulps_req(i_ulps_req), .i_data(i_data),
        .i_valid(i_valid), .o_ready(o_ready), .o_clk_lp(o_clk_lp),
        .o_clk_hs_en(o_clk_hs_en), .o_clk_toggle(o_clk_toggle), .o_dat_lp(o_dat_lp),
        .o_dat_hs_en(o_dat_hs_en), .o_stop(o_stop), .o_link_word(o_link_word),
        .o_link_valid(o_link_valid)
    );

    link_rx_model rx (.i_link_clk(i_link_clk), .i_word(o_link_word), .i_valid(o_link_valid));

    // Run lengths of each lane phase, sampled mid-cycle where outputs are settled
    always @(negedge i_clk) begin
        r_lpx  <= (o_clk_lp === 2'h1) ? r_lpx + 1 : 0;
        if (r_lpx != 0 && o_clk_lp !== 2'h1) l_lpx <= r_lpx;
        r_zero <= (o_clk_toggle === 1'b0 && (o_clk_hs_en === 1'b1 || o_clk_lp === 2'h0)) ? r_zero + 1 : 0;
        if (r_zero != 0 && o_clk_toggle === 1'b1) l_zero <= r_zero;
        if (r_zero != 0 && o_clk_toggle === 1'b0 && o_clk_hs_en !== 1'b1 && o_clk_lp !== 2'h0) l_trail <= r_zero;
        r_pre  <= (o_clk_toggle === 1'b1 && o_dat_lp === 2'h3 && o_dat_hs_en !== 1'b1) ? r_pre + 1 : 0;
        if (r_pre != 0 && o_dat_lp === 2'h1) l_pre <= r_pre;
        r_dhs  <= (o_clk_toggle === 1'b1 && o_dat_lp !== 2'h3 && o_dat_lp !== 2'h1) ? r_dhs + 1 : 0;
        // Data HS span up to the leader word at the link side, so a zero phase shows short only by more than the crossing delay
        if (r_dhs != 0 && o_link_valid === 1'b1 && o_link_word === 8'hB8) l_dhs <= r_dhs;
        r_stop <= (o_stop === 1'b1) ? r_stop + 1 : 0;
        if (r_stop != 0 && o_stop !== 1'b1) l_stop <= r_stop;
        r_wake <= (o_clk_lp === 2'h2) ? r_wake + 1 : 0;
        if (r_wake != 0 && o_clk_lp !== 2'h2) l_wake <= r_wake;
    end

    function automatic int cdiv(input int a, input int b);
        return (a + b - 1) / b;
    endfunction : cdiv

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // One word into the buffer; holds valid until the buffer takes it
    task automatic push(input word_t w);
        int k;
        @(posedge i_clk);
        i_data  <= w;
        i_valid <= 1'b1;
        k = 0;
        @(negedge i_clk);
        while (o_ready !== 1'b1 && k < 2000) begin
            @(negedge i_clk);
            k++;
        end
        check(o_ready, 1'b1, "buffer accepts word");
        @(posedge i_clk);
        i_valid <= 1'b0;
    endtask : push

    // Bounded wait for the stop flag to reach a level
    task automatic wait_stop(input logic v);
        int k;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
        end while (o_stop !== v && k < 5000);
        check(o_stop, v, "stop flag");
    endtask : wait_stop

    // Two words fill the buffer; a third is refused while idle
    task automatic t_fill;
        push(8'h11);
        push(8'h22);
        @(posedge i_clk);
        i_data  <= 8'h33;
        i_valid <= 1'b1;
        repeat (3) begin
            @(negedge i_clk);
            check(o_ready, 1'b0, "full buffer ready");
        end
        check(o_stop, 1'b1, "idle without request");
        @(posedge i_clk);
        i_valid <= 1'b0;
        $display("test fill done");
    endtask : t_fill

    // One burst at a given bit period; pre words already sit in the buffer
    task automatic t_burst(input logic [15:0] ui, input word_t w, input int base, input int pre);
        int u;
        u = ui;
        @(posedge i_clk);
        i_ui_ps     <= ui;
        i_burst_req <= 1'b1;
        wait_stop(1'b0);
        push(w);
        check(l_stop >= 5, 1'b1, "stop hold before burst");
        @(posedge i_clk);
        i_burst_req <= 1'b0;
        wait_stop(1'b1);
        // Trail length lands on the same edge that shows stop; let it settle
        @(posedge i_clk);
        check(l_pre, (u < 2500) ? 1 : cdiv(8 * u, 20000), "clock lead");
        check(l_zero >= 15, 1'b1, "clock prepare plus zero");
        check(l_trail >= 3, 1'b1, "clock trail");
        check(l_lpx >= 3, 1'b1, "low power step");
        check(l_dhs >= cdiv(145000 + 10 * u, 20000), 1'b1, "data prepare plus zero");
        check(rx.n, base + pre + 2, "word count");
        check(rx.got[base], 8'hB8, "leader word");
        check(rx.got[base + pre + 1], w, "last word");
        $display("test burst done");
    endtask : t_burst

    // Ultra-low-power entry and wake-up recovery
    task automatic t_ulps;
        @(posedge i_clk);
        i_ulps_req <= 1'b1;
        wait_stop(1'b0);
        repeat (4) @(negedge i_clk);
        check({o_clk_lp, o_dat_lp}, 4'h0, "ulps lane levels");
        @(posedge i_clk);
        i_ulps_req <= 1'b0;
        wait_stop(1'b1);
        @(posedge i_clk);
        check(l_wake, WK, "wake recovery");
        $display("test ulps done");
    endtask : t_ulps

    // Main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check({o_stop, o_ready, o_clk_lp, o_dat_lp, o_clk_hs_en, o_dat_hs_en}, 8'hFC, "reset levels");
        @(posedge i_clk);
        i_rst <= 1'b0;
        $display("test reset done");
        t_fill;
        t_burst(16'h07D0, 8'h44, 0, 2);
        check(rx.got[1], 8'h11, "first data word");
        check(rx.got[2], 8'h22, "second data word");
        t_burst(16'hC350, 8'h55, 4, 0);
        t_ulps;
        end_of_test;
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        errors++;
        $display("watchdog expired");
        end_of_test;
    end
endmodule : tb

`default_nettype wire
